// ### include/pfc_pkg.sv
/*
  Shared constants and types of the function capability configuration block:
  register offsets, field positions, reset values, capability encodings.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package pfc_pkg;

  // Limits of the function and channel scheme
  localparam int PF_MAX   = 4;
  localparam int CHAN_MAX = 256;
  localparam int VF_MAX   = 256;
  localparam int TBL_MAX  = 1023;

  // Reset values
  localparam logic [8:0] PF_CHAN_RST = 9'h004;
  localparam logic [8:0] VF_CNT_RST  = 9'h000;
  localparam logic [8:0] VF_CHAN_RST = 9'h000;
  localparam logic [9:0] PF_TBL_RST  = 10'h00f;
  localparam logic [9:0] VF_TBL_RST  = 10'h000;

  // Register byte offsets
  localparam logic [13:0] OFF_CTRL    = 14'h0000;
  localparam logic [13:0] OFF_STATUS  = 14'h0004;
  localparam logic [13:0] OFF_MSIX_PF = 14'h0008;
  localparam logic [13:0] OFF_MSIX_VF = 14'h000c;
  localparam logic [13:0] OFF_FUNC    = 14'h0010;
  localparam logic [13:0] OFF_BAR     = 14'h0020;
  localparam logic [13:0] OFF_CFG     = 14'h1000;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MULTI    = 3;
  localparam int CTRL_PF_LSB   = 4;
  localparam int CTRL_SRIOV    = 6;
  localparam int CTRL_LOCK     = 7;

  // Status fields
  localparam int ST_TOTAL_LSB = 0;
  localparam int ST_PF_LSB    = 12;
  localparam int ST_PF_MSIX   = 16;
  localparam int ST_VF_LSB    = 20;

  // Per-function fields
  localparam int FN_VFCNT_LSB = 0;
  localparam int FN_PFCH_LSB  = 9;
  localparam int FN_VFCH_LSB  = 18;

  // Per-function BAR fields
  localparam int BR_REQ_LSB   = 0;
  localparam int BR_ROM       = 6;
  localparam int BR_USER_LSB  = 8;

  // Configuration space byte offsets
  localparam logic [7:0] CFG_BAR0    = 8'h10;
  localparam logic [7:0] CFG_BAR5    = 8'h24;
  localparam logic [7:0] CFG_ROM     = 8'h30;
  localparam logic [7:0] CFG_MSIX    = 8'hb0;
  localparam logic [7:0] CFG_VF_MSIX = 8'hc0;

  // Interrupt table capability constants
  localparam logic [7:0]  MSIX_CAP_ID    = 8'h11;
  localparam logic [31:0] MSIX_TABLE_OFF = 32'h00020000;
  localparam logic [31:0] MSIX_PBA_OFF   = 32'h00030000;
  localparam logic [2:0]  MSIX_TBL_BIR   = 3'h0;
  localparam logic [2:0]  MSIX_PBA_BIR   = 3'h0;

  // BAR types and windows
  localparam logic [1:0]  BAR_OFF       = 2'h0;
  localparam logic [1:0]  BAR_PREF64    = 2'h1;
  localparam logic [1:0]  BAR_MEM64     = 2'h2;
  localparam logic [31:0] BAR_CODE_PREF = 32'h0000000c;
  localparam logic [31:0] BAR_CODE_MEM  = 32'h00000004;
  localparam logic [5:0]  DMA_WIN_BITS  = 6'h16;
  localparam int          WIN2_BITS_RST = 22;
  localparam int          USER_BITS_RST = 20;

  // User modes
  typedef enum logic [2:0] {
    multichannel_dma_mode,
    burst_master_mode,
    burst_slave_mode,
    master_slave_mode,
    master_plus_dma_mode,
    master_slave_dma_mode
  } pfc_mode_t;

  // Whole state of the register bank
  typedef struct packed {
    logic                    ack;
    logic [31:0]             rdata;
    pfc_mode_t               mode;
    logic                    multi;
    logic [1:0]              pf_last;
    logic                    sriov;
    logic                    lock;
    logic [9:0]              pf_tbl;
    logic [9:0]              vf_tbl;
    logic [PF_MAX-1:0][8:0]  vf_cnt;
    logic [PF_MAX-1:0][8:0]  pf_ch;
    logic [PF_MAX-1:0][8:0]  vf_ch;
    logic [PF_MAX-1:0][5:0]  bar_req;
    logic [PF_MAX-1:0]       rom_en;
    logic [8:0]              total;
  } pfc_state_t;

  // Modes that carry the DMA engine
  function automatic logic pfc_dma_mode(input pfc_mode_t m);
    return (m == multichannel_dma_mode) || (m == master_plus_dma_mode) ||
           (m == master_slave_dma_mode);
  endfunction : pfc_dma_mode

endpackage : pfc_pkg

// ### rtl/pfc_bar_map.sv
/*
  Resolves the effective type and window size of the even BARs of one
  physical function from the user mode and the requested types.
  Assumes requests come from registers; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module pfc_bar_map
  import pfc_pkg::*;
#(
  parameter int WIN2_BITS = WIN2_BITS_RST,
  parameter int USER_BITS = USER_BITS_RST
) (
  // Mode and requests
  input  wire logic [2:0]  mode,
  input  wire logic [5:0]  req,
  // Resolved BARs 0, 2, 4
  output logic [5:0]       eff_type,
  output logic [17:0]      win_bits,
  output logic [5:0]       user_avail
);

  pfc_mode_t m;          // Mode as enum
  logic      dma;        // DMA engine present

  assign m   = pfc_mode_t'(mode);
  assign dma = pfc_dma_mode(m);

  // Per-BAR resolution
  always_comb begin
    user_avail = 6'h00;
    for (int i = 0; i < 3; i++) begin
      // Illegal request code reads as disabled
      eff_type[2*i +: 2] = (req[2*i +: 2] == 2'h3) ? BAR_OFF : req[2*i +: 2];
      win_bits[6*i +: 6] = 6'(USER_BITS);
      user_avail[2*i]    = 1'b1;
    end
    // Engine registers own BAR0 when DMA is present
    if (dma) begin
      eff_type[1:0]  = BAR_PREF64;
      win_bits[5:0]  = DMA_WIN_BITS;
      user_avail[0]  = 1'b0;
    end
    // Pure DMA mode reserves BAR2 and drops BAR4
    if (m == multichannel_dma_mode) begin
      eff_type[3:2]  = BAR_PREF64;
      win_bits[11:6] = 6'(WIN2_BITS);
      eff_type[5:4]  = BAR_OFF;
      user_avail[2]  = 1'b0;
      user_avail[4]  = 1'b0;
    end
  end

endmodule : pfc_bar_map

`default_nettype wire

// ### rtl/pfc_config.sv
/*
  Function capability and BAR configuration bank: function counts, DMA
  channel budget, interrupt table capability and a read-only view of each
  physical function's configuration space, all over Avalon-MM.
  Assumes one clock, a master that holds requests until waitrequest is low.
*/
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pfc_config
  import pfc_pkg::*;
#(
  // Physical functions built; the control field can only name these
  parameter int NUM_PF     = PF_MAX,
  // Channel budget shared by every function
  parameter int CHAN_LIMIT = CHAN_MAX,
  // Window widths of the BARs, in address bits
  parameter int WIN2_BITS  = WIN2_BITS_RST,
  parameter int USER_BITS  = USER_BITS_RST
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Avalon-MM register slave
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Resolved configuration
  output logic [2:0]       pf_count,
  output logic [8:0]       channel_total,
  output logic             config_locked
);

  // Refuse settings the logic cannot serve
  // Windows under 4 KB cannot be decoded; past 63 bits no base is left
  // The PF count field is two bits wide, hence four at most
  if (NUM_PF < 1 || NUM_PF > PF_MAX || CHAN_LIMIT < 1 || CHAN_LIMIT > CHAN_MAX ||
      WIN2_BITS < 12 || WIN2_BITS > 63 || USER_BITS < 12 || USER_BITS > 63) begin : g_bad
    $error("pfc_config: parameter out of range");
  end

  // Bank state and the working values of the current request
  pfc_state_t               s;          // Registered state
  pfc_state_t               next_s;     // Next state
  pfc_state_t               cand;       // Candidate after a write
  logic [PF_MAX-1:0][5:0]   eff_type;   // Resolved even BAR types
  logic [PF_MAX-1:0][17:0]  win_bits;   // Resolved window widths
  logic [PF_MAX-1:0][5:0]   user_avail; // BARs left to the user
  logic [31:0]              rd;         // Read value at address
  logic [31:0]              mask;       // Byte-lane mask
  logic [31:0]              wv;         // Merged write value
  logic [1:0]               idx;        // Function index of address
  logic [7:0]               coff;       // Config space byte offset
  logic                     req;        // Request pending

  // One resolver per physical function
  // Built for every PF slot; slots at or past NUM_PF are never read out
  for (genvar g = 0; g < PF_MAX; g++) begin : g_bar
    pfc_bar_map #(
      .WIN2_BITS (WIN2_BITS),
      .USER_BITS (USER_BITS)
    ) u_map (
      .mode       (s.mode),
      .req        (s.bar_req[g]),
      .eff_type   (eff_type[g]),
      .win_bits   (win_bits[g]),
      .user_avail (user_avail[g])
    );
  end

  // Channels used by one function and its VFs
  // VFs draw channels only while virtualization is on
  function automatic logic [17:0] fn_chan(input pfc_state_t c, input int f);
    logic [17:0] v;
    v = {9'h000, c.pf_ch[f]};
    if (c.sriov) begin
      // Both factors widened first so 256 by 256 cannot wrap
      v = v + (18'(c.vf_cnt[f]) * 18'(c.vf_ch[f]));
    end
    return v;
  endfunction : fn_chan

  // Channel sum over all enabled functions
  // PFs past the enabled count draw nothing, whatever they hold
  function automatic logic [19:0] sum_chan(input pfc_state_t c);
    logic [19:0] t;
    logic [1:0]  last;
    t    = 20'h00000;
    last = c.multi ? c.pf_last : 2'h0;
    for (int f = 0; f < NUM_PF; f++) begin
      if (2'(f) <= last) begin
        t = t + {2'h0, fn_chan(c, f)};
      end
    end
    return t;
  endfunction : sum_chan

  // Sizing readback of one BAR word, as after all ones written
  // Odd words reuse the even BAR's type, as the upper half of the pair
  function automatic logic [31:0] bar_word(input logic [5:0] typ3, input logic [17:0] bits3,
                                           input logic [2:0] n);
    logic [63:0] m64;
    logic [1:0]  t;
    t   = typ3[2*(n/2) +: 2];
    m64 = 64'hffffffffffffffff << bits3[6*(n/2) +: 6];
    if (t == BAR_OFF) begin
      return 32'h00000000;
    end else if (n[0]) begin
      return m64[63:32];
    end else begin
      return m64[31:0] | ((t == BAR_PREF64) ? BAR_CODE_PREF : BAR_CODE_MEM);
    end
  endfunction : bar_word

  // Request flag, function index and config space byte offset
  assign req  = avs_read | avs_write;
  assign idx  = avs_address[3:2];
  assign coff = {avs_address[7:2], 2'h0};

  // Read decode, shared by reads and masked writes
  // Unmapped addresses and absent functions read as zero
  always_comb begin
    logic       fn_ok;
    logic       dma;
    logic [2:0] bn;
    fn_ok = 1'b0;
    dma   = pfc_dma_mode(s.mode);
    bn    = 3'h0;
    rd    = 32'h00000000;
    if (avs_address[13:2] == OFF_CTRL[13:2]) begin
      // Control: mode, PF count, virtualization, lock
      rd[CTRL_MODE_LSB +: 3] = s.mode;
      rd[CTRL_MULTI]         = s.multi;
      rd[CTRL_PF_LSB +: 2]   = s.pf_last;
      rd[CTRL_SRIOV]         = s.sriov;
      rd[CTRL_LOCK]          = s.lock;
    end else if (avs_address[13:2] == OFF_STATUS[13:2]) begin
      // Status is derived, never written; its total is the registered s.total
      rd[ST_TOTAL_LSB +: 9] = s.total;
      rd[ST_PF_LSB +: 3]    = pf_count;
      rd[ST_PF_MSIX]        = dma;
      for (int f = 0; f < NUM_PF; f++) begin
        rd[ST_VF_LSB + f] = dma && s.sriov && (s.vf_cnt[f] != 9'h000) && (3'(f) < pf_count);
      end
    end else if (avs_address[13:2] == OFF_MSIX_PF[13:2]) begin
      rd[9:0] = s.pf_tbl;
    end else if (avs_address[13:2] == OFF_MSIX_VF[13:2]) begin
      rd[9:0] = s.vf_tbl;
    end else if (avs_address[13:4] == OFF_FUNC[13:4] && 32'(idx) < NUM_PF) begin
      rd[FN_VFCNT_LSB +: 9] = s.vf_cnt[idx];
      rd[FN_PFCH_LSB +: 9]  = s.pf_ch[idx];
      rd[FN_VFCH_LSB +: 9]  = s.vf_ch[idx];
    end else if (avs_address[13:4] == OFF_BAR[13:4] && 32'(idx) < NUM_PF) begin
      rd[BR_REQ_LSB +: 6]  = s.bar_req[idx];
      rd[BR_ROM]           = s.rom_en[idx];
      rd[BR_USER_LSB +: 6] = user_avail[idx];
    end else if (avs_address[13:12] == OFF_CFG[13:12] && avs_address[11:10] == 2'h0) begin
      // Configuration space of physical function in bits 9:8
      // BARs read back their sizing pattern; the ROM reads its enable
      fn_ok = ({1'b0, avs_address[9:8]} < pf_count);
      if (fn_ok && coff >= CFG_BAR0 && coff <= CFG_BAR5) begin
        bn = 3'((coff - CFG_BAR0) >> 2);
        rd = bar_word(eff_type[avs_address[9:8]], win_bits[avs_address[9:8]], bn);
      end else if (fn_ok && coff == CFG_ROM) begin
        rd = {31'h00000000, s.rom_en[avs_address[9:8]]};
      end else if (fn_ok && dma && coff == CFG_MSIX) begin
        // Fixed fields; only the table size is set by the bank
        rd = {5'h00, 1'b0, s.pf_tbl, 8'h00, MSIX_CAP_ID};
      end else if (fn_ok && dma && coff == CFG_MSIX + 8'h04) begin
        rd = {MSIX_TABLE_OFF[31:3], MSIX_TBL_BIR};
      end else if (fn_ok && dma && coff == CFG_MSIX + 8'h08) begin
        rd = {MSIX_PBA_OFF[31:3], MSIX_PBA_BIR};
      end else if (fn_ok && dma && s.sriov && s.vf_cnt[avs_address[9:8]] != 9'h000) begin
        // Virtual function capability copy
        if (coff == CFG_VF_MSIX) begin
          rd = {5'h00, 1'b0, s.vf_tbl, 8'h00, MSIX_CAP_ID};
        end else if (coff == CFG_VF_MSIX + 8'h04) begin
          rd = {MSIX_TABLE_OFF[31:3], MSIX_TBL_BIR};
        end else if (coff == CFG_VF_MSIX + 8'h08) begin
          rd = {MSIX_PBA_OFF[31:3], MSIX_PBA_BIR};
        end
      end
    end
  end

  // Byte-lane merge so partial writes keep other lanes
  // The merge reads through the decode, so lanes not enabled come back as they were
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      mask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
    wv = (rd & ~mask) | (avs_writedata & mask);
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    cand   = s;
    // Writes land on the edge where waitrequest is seen low
    // Lock is sticky, so once set no write passes this gate again
    if (s.ack && avs_write && !s.lock) begin
      if (avs_address[13:2] == OFF_CTRL[13:2]) begin
        // Fields are taken together, but each is vetted on its own
        // Unknown mode codes keep the old mode
        if (wv[CTRL_MODE_LSB +: 3] <= 3'(master_slave_dma_mode)) begin
          cand.mode = pfc_mode_t'(wv[CTRL_MODE_LSB +: 3]);
        end
        cand.multi = wv[CTRL_MULTI];
        if (32'(wv[CTRL_PF_LSB +: 2]) < NUM_PF) begin
          cand.pf_last = wv[CTRL_PF_LSB +: 2];
        end
        cand.sriov = wv[CTRL_SRIOV];
        cand.lock  = wv[CTRL_LOCK];
      end else if (avs_address[13:2] == OFF_MSIX_PF[13:2]) begin
        cand.pf_tbl = wv[9:0];
      end else if (avs_address[13:2] == OFF_MSIX_VF[13:2]) begin
        cand.vf_tbl = wv[9:0];
      end else if (avs_address[13:4] == OFF_FUNC[13:4] && 32'(idx) < NUM_PF) begin
        // Counts above 256 are refused field by field
        // A refused field keeps its value; the others of the word still land
        if (32'(wv[FN_VFCNT_LSB +: 9]) <= VF_MAX) begin
          cand.vf_cnt[idx] = wv[FN_VFCNT_LSB +: 9];
        end
        if (32'(wv[FN_PFCH_LSB +: 9]) <= CHAN_MAX) begin
          cand.pf_ch[idx] = wv[FN_PFCH_LSB +: 9];
        end
        if (32'(wv[FN_VFCH_LSB +: 9]) <= CHAN_MAX) begin
          cand.vf_ch[idx] = wv[FN_VFCH_LSB +: 9];
        end
      end else if (avs_address[13:4] == OFF_BAR[13:4] && 32'(idx) < NUM_PF) begin
        // Type code 3 is kept as written but resolves to disabled
        cand.bar_req[idx] = wv[BR_REQ_LSB +: 6];
        cand.rom_en[idx]  = wv[BR_ROM];
      end
      // Configuration window and status take no writes
      // Unmapped write addresses fall through and change nothing
    end
    // Whole write dropped if it would overrun the channel budget
    // Checking the whole candidate keeps the sum exact across fields
    if (sum_chan(cand) <= 20'(CHAN_LIMIT)) begin
      next_s = cand;
    end
    // Handshake: one wait cycle, then answer
    // A request still held after the answer starts a fresh wait
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      next_s.rdata = rd;
    end
    // Registered total keeps the adder chain off the output pin
    next_s.total = 9'(sum_chan(s));
  end

  // State register
  // Fields with nonzero reset values are named after the clear
  // Reset holds only constants, as the async branch must
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s         <= '0;
      s.mode    <= multichannel_dma_mode;
      s.pf_tbl  <= PF_TBL_RST;
      s.vf_tbl  <= VF_TBL_RST;
      s.vf_cnt  <= {PF_MAX{VF_CNT_RST}};
      s.pf_ch   <= {PF_MAX{PF_CHAN_RST}};
      s.vf_ch   <= {PF_MAX{VF_CHAN_RST}};
      s.total   <= PF_CHAN_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  // Waitrequest is combinational so each access costs one wait only
  // The PF count is derived, so it follows the control word at once
  assign avs_waitrequest = req && !s.ack;
  assign avs_readdata    = s.rdata;
  assign pf_count        = s.multi ? ({1'b0, s.pf_last} + 3'h1) : 3'h1;
  assign channel_total   = s.total;
  assign config_locked   = s.lock;

endmodule : pfc_config

`default_nettype wire

// ### bench/pfc_config_asserts.sv
/*
  Checker of the function configuration bank, bound to its top module.
  Assumes one clock and an async active-low reset; sees top ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module pfc_config_asserts
  import pfc_pkg::*;
#(
  parameter int CHAN_LIMIT = CHAN_MAX
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Register bus
  input wire logic [13:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Resolved configuration
  input wire logic [2:0]  pf_count,
  input wire logic [8:0]  channel_total,
  input wire logic        config_locked
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Read answered this cycle inside the config window
  logic cfg_rd;
  assign cfg_rd = avs_read && !avs_waitrequest && (avs_address[13:12] == 2'h1);

  // One wait cycle, then the answer
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  property p_rd_wait;
    $rose(avs_read) |-> s_one_wait;
  endproperty
  property p_wr_wait;
    $rose(avs_write) |-> s_one_wait;
  endproperty
  property p_pf_range;
    (pf_count >= 3'h1) && (pf_count <= 3'h4);
  endproperty
  property p_chan_cap;
    int'(channel_total) <= CHAN_LIMIT;
  endproperty
  property p_lock_sticky;
    config_locked |=> config_locked;
  endproperty
  // Two locked cycles first, since the total lags its registers by one
  property p_lock_frozen;
    config_locked [*2] |=> $stable(channel_total);
  endproperty
  property p_tbl_size;
    avs_read && !avs_waitrequest && (avs_address == 14'h0008) |-> avs_readdata[31:10] == 22'h0;
  endproperty
  property p_tbl_off;
    cfg_rd && (avs_address[7:0] inside {8'hb4, 8'hc4})
      |-> avs_readdata inside {32'h00020000, 32'h0};
  endproperty
  property p_pba_off;
    cfg_rd && (avs_address[7:0] inside {8'hb8, 8'hc8})
      |-> avs_readdata inside {32'h00030000, 32'h0};
  endproperty
  property p_bar_code;
    cfg_rd && (avs_address[7:0] inside {8'h10, 8'h18, 8'h20})
      |-> avs_readdata[3:0] inside {4'h0, 4'h4, 4'hc};
  endproperty

  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
  a_pf_range: assert property (p_pf_range) else $error("pf count out of range");
  a_chan_cap: assert property (p_chan_cap) else $error("channel total over limit");
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");
  a_lock_frozen: assert property (p_lock_frozen) else $error("locked total moved");
  a_tbl_size: assert property (p_tbl_size) else $error("table size too wide");
  a_tbl_off: assert property (p_tbl_off) else $error("table offset wrong");
  a_pba_off: assert property (p_pba_off) else $error("pending offset wrong");
  a_bar_code: assert property (p_bar_code) else $error("bar type code wrong");
endmodule : pfc_config_asserts

bind pfc_config pfc_config_asserts #(.CHAN_LIMIT(CHAN_LIMIT)) pfc_config_asserts_inst (
  .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pf_count(pf_count),
  .channel_total(channel_total), .config_locked(config_locked));

`default_nettype wire

// ### bench/pfc_host_model.sv
/*
  Host-side register master standing in for enumeration software.
  Assumes the bench calls access() one request at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module pfc_host_model (
  // Clock
  input  wire logic        clock,
  // Avalon-MM master
  output logic [13:0]      avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Bus never answered
  output logic             hung
);
  // Idle bus from time zero
  initial begin
    avs_address    = 14'h0000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    hung           = 1'b0;
  end

  // One access; waitrequest is read at each rising edge, before that edge's updates land
  task automatic access(input logic wr, input logic [13:0] a, input logic [31:0] d,
                        output logic [31:0] q, input logic [3:0] be = 4'hf);
    int n;
    n = 0;
    @(posedge clock);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    // Request stands until the edge that sees waitrequest low
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    hung = hung | (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    // Released right at the accepting edge
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : access
endmodule : pfc_host_model

`default_nettype wire

// ### bench/pfc_config_tb.sv
/*
  Self-checking bench of the function configuration bank.
  Assumes the host model drives the register bus and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module pfc_config_tb import pfc_pkg::*;;
  localparam int DMA_BITS = 22; // 4 MB engine window
  logic        clock;
  logic        rst_b;
  logic [13:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  pf_count;
  logic [8:0]  channel_total;
  logic        config_locked;
  logic        hung;
  logic [31:0] q;
  int          error_cnt = 0;
  int          comparisons = 0;

  pfc_config pfc_config_inst (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pf_count(pf_count),
    .channel_total(channel_total), .config_locked(config_locked));
  pfc_host_model pfc_host_model_inst (.clock(clock), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hung(hung));

  // Sizing pattern of a 64-bit BAR low word
  function automatic logic [31:0] bar_lo(input int bits, input logic pref);
    return ~((32'h1 << bits) - 32'h1) | (pref ? 32'hc : 32'h4);
  endfunction : bar_lo

  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // A bus that never answers ends the run
  task automatic guard;
    if (hung) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : guard

  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    pfc_host_model_inst.access(1'b1, a, d, q, be);
    guard();
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    pfc_host_model_inst.access(1'b0, a, 32'h0, q);
    guard();
    `CHECK(q & m, e & m)
  endtask : rd

  // Total lags its registers by one cycle
  task automatic pins(input logic [2:0] pc, input logic [8:0] ct);
    repeat (2) @(negedge clock);
    `CHECK(pf_count, pc)
    `CHECK(channel_total, ct)
  endtask : pins

  task automatic defaults;
    rd(14'h0000, 32'h0);
    rd(14'h0008, 32'h0000000f);
    rd(14'h000c, 32'h0);
    rd(14'h0010, 32'h00000800);
    rd(14'h0004, 32'h00011004);
    pins(3'h1, 9'h004);
  endtask : defaults

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    bit dma;
    rst_b = 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    defaults();
    // Pure DMA mode view of PF0
    rd(14'h10b0, 32'h000f0011, 32'h03ff00ff);
    rd(14'h10b4, 32'h00020000);
    rd(14'h10b8, 32'h00030000);
    rd(14'h1010, bar_lo(DMA_BITS, 1'b1));
    rd(14'h1014, 32'hffffffff);
    rd(14'h1018, bar_lo(WIN2_BITS_RST, 1'b1));
    rd(14'h1020, 32'h0);
    rd(14'h1024, 32'h0);
    rd(14'h10c4, 32'h0);
    // Writes to fixed places are dropped
    wr(14'h10b4, 32'h0);
    wr(14'h0004, 32'hffffffff);
    rd(14'h10b4, 32'h00020000);
    rd(14'h0004, 32'h00011004);
    rd(14'h0100, 32'h0);
    // Count field alone, then with multi-function enabled
    wr(14'h0000, 32'h00000030);
    pins(3'h1, 9'h004);
    wr(14'h0000, 32'h00000038);
    pins(3'h4, 9'h010);
    // Channel budget at and over the limit
    wr(14'h0010, 32'h00020000);
    rd(14'h0010, 32'h00000800);
    wr(14'h0010, 32'h0001e800);
    pins(3'h4, 9'h100);
    wr(14'h0014, 32'h00000a00);
    rd(14'h0014, 32'h00000800);
    // Virtual functions under virtualization
    wr(14'h0000, 32'h00000078);
    wr(14'h0010, 32'h000c0802);
    pins(3'h4, 9'h016);
    rd(14'h0004, 32'h00114016);
    wr(14'h0010, 32'h000c0901);
    rd(14'h0010, 32'h000c0802);
    rd(14'h11c4, 32'h0);
    wr(14'h0008, 32'h000003ff);
    rd(14'h10b0, 32'h03ff0000, 32'h03ff0000);
    wr(14'h000c, 32'h000003ff);
    rd(14'h10c0, 32'h03ff0000, 32'h03ff0000);
    // Only lane 0 of a table size write lands
    wr(14'h0008, 32'h0, 4'h1);
    rd(14'h0008, 32'h00000300);
    // Every mode with BAR0/2 prefetchable, BAR4 plain, ROM on
    wr(14'h0020, 32'h00000065);
    for (int m = 0; m < 6; m++) begin
      dma = (m == 0) || (m == 4) || (m == 5);
      wr(14'h0000, 32'h00000078 | m);
      rd(14'h1010, bar_lo(dma ? DMA_BITS : USER_BITS_RST, 1'b1));
      rd(14'h10b4, dma ? 32'h00020000 : 32'h0);
      rd(14'h10c4, dma ? 32'h00020000 : 32'h0);
      rd(14'h1018, bar_lo(m == 0 ? WIN2_BITS_RST : USER_BITS_RST, 1'b1));
      rd(14'h101c, 32'hffffffff);
      rd(14'h1020, m == 0 ? 32'h0 : bar_lo(USER_BITS_RST, 1'b0));
      rd(14'h1030, 32'h1, 32'h1);
    end
    // Lock freezes everything
    wr(14'h0000, 32'h000000f8);
    wr(14'h0008, 32'h00000005);
    rd(14'h0008, 32'h00000300);
    wr(14'h0000, 32'h0);
    rd(14'h0000, 32'h000000f8, 32'h000000ff);
    `CHECK(config_locked, 1'b1)
    // Second reset in mid-run
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    defaults();
    `CHECK(config_locked, 1'b0)
    tally_and_finish();
  end
endmodule : pfc_config_tb

`default_nettype wire
